// *** rxfc_defs.svh ***
/*
  Constants of the receive flow-control trigger: register offsets, field
  positions, reset values and timing counts.
  Assumes a 10 MHz system clock and inclusion by bare name.
*/
`ifndef RXFC_DEFS_SVH
`define RXFC_DEFS_SVH

`define RXFC_CFG_ADDR        12'h0AC
`define RXFC_STAT_ADDR       12'h0B4
`define RXFC_CFG_RESET       32'h0000_0000
`define RXFC_CFG_WMASK       32'h00FF_FFFF
`define RXFC_ANY_BIT         0
`define RXFC_OWN_BIT         1
`define RXFC_ALL_BIT         2
`define RXFC_GRP_BIT         3
`define RXFC_CODE_LSB        4
`define RXFC_CODE_MSB        7
`define RXFC_REL_LSB         8
`define RXFC_REL_MSB         15
`define RXFC_TRIG_LSB        16
`define RXFC_TRIG_MSB        23
`define RXFC_CLK_MHZ         10
`define RXFC_SLOW_EXTRA_NS   2200
`define RXFC_EXTRA_CYC       ((`RXFC_SLOW_EXTRA_NS * `RXFC_CLK_MHZ) / 1000)
`define RXFC_UNIT_SHIFT      6

`endif

// *** rxfc_pkg.sv ***
/*
  Types of the receive flow-control trigger.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package rxfc_pkg;
  typedef struct packed {
    logic [7:0] pause_trigger_level;
    logic [7:0] pause_release_level;
    logic [3:0] backpressure_time_code;
    logic       flow_on_group_frame;
    logic       flow_on_all_stations_frame;
    logic       flow_on_own_address_frame;
    logic       flow_on_any_frame;
  } rxfc_cfg_type;

  typedef struct packed {
    logic sof;
    logic own_match;
    logic group_match;
    logic all_match;
  } rxfc_frame_type;

  typedef enum logic [1:0] {
    RXFC_IDLE,
    RXFC_ARMED,
    RXFC_PAUSED
  } rxfc_state_type;
endpackage
`default_nettype wire

// *** rxfc_bp_timer.sv ***
/*
  Back-pressure duration timer: maps the time code and link speed to a
  cycle count, loads it at start and counts down.
  Assumes a 10 MHz clock; start is a one-cycle pulse.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_defs.svh"

module rxfc_bp_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic [3:0] code,
  input  wire logic       speed_100,
  output var  logic       busy
);
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;
  logic [12:0] load_val;
  logic [12:0] base_us;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (code)
      4'h0:    base_us = 13'h0005;
      4'h1:    base_us = 13'h000A;
      4'h2:    base_us = 13'h000F;
      4'h3:    base_us = 13'h0019;
      default: base_us = 13'((code - 4'h3) * 50);
    endcase
    // Timer counts cycles; 10 cycles per us at 10 MHz
    load_val = 13'(base_us * `RXFC_CLK_MHZ);
    if (!speed_100) begin
      load_val = 13'(load_val + `RXFC_EXTRA_CYC);
    end
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = load_val;
    end else if (cnt_q != 13'h0000) begin
      cnt_d = cnt_q - 13'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 13'h0000;
      busy  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy  <= (cnt_d != 13'h0000);
    end
  end
endmodule
`default_nettype wire

// *** rxfc_top.sv ***
/*
  Receive flow-control trigger with its APB configuration register.
  Watches receive FIFO occupancy and frame starts; drives half-duplex
  back pressure and full-duplex pause requests to the MAC.
  Assumes the MAC acknowledges a pause request with a one-cycle pulse and
  never aborts a frame it is already sending.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_defs.svh"

module rxfc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic [13:0] fifo_used,
  input  wire logic        full_duplex,
  input  wire logic        speed_100,
  input  wire logic        tx_enabled,
  input  wire logic        rx_sof,
  input  wire logic        rx_own_match,
  input  wire logic        rx_group_match,
  input  wire logic        rx_all_match,
  input  wire logic        pause_ack,
  output var  logic        pause_req,
  output var  logic        pause_zero,
  output var  logic        backpressure
);
  rxfc_pkg::rxfc_cfg_type   cfg;
  rxfc_pkg::rxfc_frame_type frm;
  rxfc_pkg::rxfc_state_type st_q;
  rxfc_pkg::rxfc_state_type st_d;
  logic [31:0] cfg_q;
  logic [31:0] cfg_d;
  logic [31:0] rdata_d;
  logic        slverr_d;
  logic        pready_d;
  logic        req_q;
  logic        req_d;
  logic        zero_q;
  logic        zero_d;
  logic        bp_start;
  logic        bp_busy;
  logic        bp_q;
  logic        bp_d;
  logic        at_trigger;
  logic        below_release;
  logic        type_hit;
  logic        setup;
  logic        wr_en;
  logic [31:0] wmask;
  logic [2:0]  type_en;
  logic [2:0]  type_seen;
  logic [2:0]  type_match;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait states; read data is registered during the setup phase
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign wmask[gi*8 +: 8] = {8{pstrb[gi]}};
    end
  endgenerate

  always_comb begin
    cfg_d    = cfg_q;
    rdata_d  = prdata;
    slverr_d = pslverr;
    pready_d = 1'b0;
    if (setup) begin
      pready_d = 1'b1;
      slverr_d = 1'b0;
      if (paddr == `RXFC_CFG_ADDR) begin
        rdata_d = cfg_q;
      end else if (paddr == `RXFC_STAT_ADDR) begin
        rdata_d = {29'h0000_0000, bp_q, zero_q, req_q};
      end else begin
        rdata_d  = 32'h0000_0000;
        slverr_d = 1'b1;
      end
      if (pwrite) begin
        rdata_d = 32'h0000_0000;
      end
    end
    if (wr_en && paddr == `RXFC_CFG_ADDR) begin
      cfg_d = (cfg_q & ~(wmask & `RXFC_CFG_WMASK))
            | (pwdata & wmask & `RXFC_CFG_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= `RXFC_CFG_RESET;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      prdata  <= rdata_d;
      pslverr <= slverr_d;
      pready  <= pready_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field views of the configuration word
  always_comb begin
    cfg.pause_trigger_level = cfg_q[`RXFC_TRIG_MSB:`RXFC_TRIG_LSB];
    cfg.pause_release_level = cfg_q[`RXFC_REL_MSB:`RXFC_REL_LSB];
    cfg.backpressure_time_code = cfg_q[`RXFC_CODE_MSB:`RXFC_CODE_LSB];
    cfg.flow_on_group_frame        = cfg_q[`RXFC_GRP_BIT];
    cfg.flow_on_all_stations_frame = cfg_q[`RXFC_ALL_BIT];
    cfg.flow_on_own_address_frame  = cfg_q[`RXFC_OWN_BIT];
    cfg.flow_on_any_frame          = cfg_q[`RXFC_ANY_BIT];
    frm.sof             = rx_sof;
    frm.own_match       = rx_own_match;
    frm.group_match     = rx_group_match;
    frm.all_match       = rx_all_match;
  end

  // Level of zero would trigger on an empty FIFO; treat it as off
  assign at_trigger = (cfg.pause_trigger_level != 8'h00) &&
    ({2'b00, fifo_used} >=
     ({8'h00, cfg.pause_trigger_level} << `RXFC_UNIT_SHIFT));
  // Strict compare: a release level of zero never releases
  assign below_release = ({2'b00, fifo_used} <
     ({8'h00, cfg.pause_release_level} << `RXFC_UNIT_SHIFT));

  // Per-type match: enable bit and frame class line up bit for bit
  assign type_en   = {cfg.flow_on_group_frame,
                      cfg.flow_on_all_stations_frame,
                      cfg.flow_on_own_address_frame};
  assign type_seen = {frm.group_match, frm.all_match, frm.own_match};

  genvar gt;
  generate
    for (gt = 0; gt < 3; gt = gt + 1) begin : g_type
      assign type_match[gt] = type_en[gt] && type_seen[gt];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Half-duplex back pressure
  always_comb begin
    // No address decode in any-frame mode: the frame start alone counts
    if (cfg.flow_on_any_frame) begin
      type_hit = frm.sof;
    end else begin
      type_hit = frm.sof && (|type_match);
    end
    bp_start = !full_duplex && tx_enabled && at_trigger && type_hit
               && !bp_busy;
    bp_d = !full_duplex && (bp_start || bp_busy);
  end

  rxfc_bp_timer u_timer (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (bp_start),
    .code      (cfg.backpressure_time_code),
    .speed_100 (speed_100),
    .busy      (bp_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Full-duplex pause sequencing
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    zero_d = zero_q;
    if (req_q && pause_ack) begin
      req_d = 1'b0;
    end
    case (st_q)
      rxfc_pkg::RXFC_IDLE: begin
        if (full_duplex && cfg.flow_on_any_frame && tx_enabled
            && at_trigger && !req_q) begin
          req_d  = 1'b1;
          zero_d = 1'b0;
          st_d   = rxfc_pkg::RXFC_ARMED;
        end
      end
      rxfc_pkg::RXFC_ARMED: begin
        // Hold until the MAC sends it at its next opening
        if (!req_q || pause_ack) begin
          st_d = rxfc_pkg::RXFC_PAUSED;
        end
      end
      rxfc_pkg::RXFC_PAUSED: begin
        // Leaving full duplex or any-frame mode cancels the zero pause
        if (!full_duplex || !cfg.flow_on_any_frame) begin
          st_d = rxfc_pkg::RXFC_IDLE;
        end else if (below_release && tx_enabled && !req_q) begin
          req_d  = 1'b1;
          zero_d = 1'b1;
          st_d   = rxfc_pkg::RXFC_IDLE;
        end
      end
      default: st_d = rxfc_pkg::RXFC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= rxfc_pkg::RXFC_IDLE;
      req_q        <= 1'b0;
      zero_q       <= 1'b0;
      bp_q         <= 1'b0;
      pause_req    <= 1'b0;
      pause_zero   <= 1'b0;
      backpressure <= 1'b0;
    end else begin
      st_q         <= st_d;
      req_q        <= req_d;
      zero_q       <= zero_d;
      bp_q         <= bp_d;
      pause_req    <= req_d;
      pause_zero   <= zero_d;
      backpressure <= bp_d;
    end
  end
endmodule
`default_nettype wire

// *** rxfc_top_peer.sv ***
/* MAC side of the pause request: takes a pause after a set wait.
   Assumes pause_req is held until acknowledged. */
`timescale 1ns/1ps
`default_nettype none
module rxfc_top_peer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pause_req,
  input  wire logic [7:0] ack_wait,
  output var  logic       pause_ack
);
  logic [7:0] wait_q;
  // A busy transmitter finishes its frame first, so the wait varies
  // Compare with >= so a wait shortened mid-request still ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pause_ack <= 1'b0;
      wait_q    <= 8'h00;
    end else if (!pause_req || pause_ack) begin
      pause_ack <= 1'b0;
      wait_q    <= 8'h00;
    end else if (wait_q >= ack_wait) begin
      pause_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 8'h01;
    end
  end
endmodule
`default_nettype wire

// *** rxfc_top_assertions.sv ***
/* Output checks of the flow-control trigger.
   Bound into rxfc_top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module rxfc_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic full_duplex,
  input wire logic tx_enabled,
  input wire logic rx_sof,
  input wire logic pause_ack,
  input wire logic pause_req,
  input wire logic pause_zero,
  input wire logic backpressure
);
  int bp_n;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) bp_n <= 0;
    else bp_n <= backpressure ? bp_n + 1 : 0;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  rdy_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  pause_hold_a: assert property (pause_req && !pause_ack |=> pause_req)
    else $error("pause request dropped early");
  pause_once_a: assert property (pause_req && pause_ack |=> !pause_req)
    else $error("pause request kept after ack");
  pause_cause_a: assert property ($rose(pause_req) |->
    $past(full_duplex) && $past(tx_enabled)) else $error("pause uncaused");
  zero_steady_a: assert property (pause_req && !pause_ack |=>
    $stable(pause_zero)) else $error("zero flag moved");
  bp_cause_a: assert property ($rose(backpressure) |->
    $past(rx_sof) && $past(tx_enabled) && !$past(full_duplex))
    else $error("jam uncaused");
  bp_min_a: assert property ($rose(backpressure) |-> backpressure[*8])
    else $error("jam too short");
  bp_max_a: assert property (bp_n <= 6023)
    else $error("jam too long");
endmodule
bind rxfc_top rxfc_top_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready),
  .full_duplex(full_duplex), .tx_enabled(tx_enabled), .rx_sof(rx_sof),
  .pause_ack(pause_ack), .pause_req(pause_req), .pause_zero(pause_zero),
  .backpressure(backpressure));
`default_nettype wire

// *** rxfc_top_tb_top.sv ***
/* Self-checking bench of the flow-control trigger.
   Assumes the peer model answers pause requests. */
`timescale 1ns/1ps
`default_nettype none
`include "rxfc_defs.svh"
module rxfc_top_tb_top;
  logic        pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [13:0] fifo_used;
  logic        pready, pslverr, full_duplex, speed_100, tx_enabled, rx_sof;
  logic        rx_own_match, rx_group_match, rx_all_match, pause_ack;
  logic        pause_req, pause_zero, backpressure;
  logic [7:0]  ack_wait;
  int          failures = 0, tests_run = 0;
  bit          exp_q[$];
  always #50 pclk = ~pclk;
  rxfc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_used(fifo_used), .full_duplex(full_duplex),
    .speed_100(speed_100), .tx_enabled(tx_enabled), .rx_sof(rx_sof),
    .rx_own_match(rx_own_match), .rx_group_match(rx_group_match),
    .rx_all_match(rx_all_match), .pause_ack(pause_ack),
    .pause_req(pause_req), .pause_zero(pause_zero),
    .backpressure(backpressure));
  rxfc_top_peer u_peer (.pclk(pclk), .presetn(presetn),
    .pause_req(pause_req), .ack_wait(ack_wait), .pause_ack(pause_ack));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    chk("pready", pready, 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // Jam length in cycles at 10 MHz; the slow link adds 2.2 us
  function automatic int bp_cycles(int c, bit s);
    int us;
    us = c < 4 ? (c == 3 ? 25 : 5 * (c + 1)) : 50 * (c - 3);
    return us * 10 + (s ? 0 : 22);
  endfunction
  // Every pause taken must be one the model expects
  always @(posedge pclk)
    if (pause_req === 1'b1 && pause_ack === 1'b1) begin
      if (exp_q.size() == 0) chk("extra pause", 1, 0);
      else chk("zero flag", pause_zero, exp_q.pop_front());
    end
  initial begin
    #9_000_000;
    failures++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    logic e;
    logic [3:0] nib;
    logic [2:0] m;
    int n, x, on;
    {psel, penable, pwrite, paddr, pwdata, rx_sof} = '0;
    {rx_own_match, rx_group_match, rx_all_match, full_duplex} = '0;
    {pstrb, fifo_used, speed_100, tx_enabled} = {4'hF, 14'h0, 2'b11};
    {presetn, ack_wait} = {1'b0, 8'h05};
    void'($urandom(32'ha8c9));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `RXFC_CFG_ADDR, 0, r, e);
    chk("cfg reset", r, `RXFC_CFG_RESET);
    apb(1'b1, `RXFC_CFG_ADDR, 32'hFFFF_FFFF, r, e);
    apb(1'b0, `RXFC_CFG_ADDR, 0, r, e);
    chk("cfg fields", r, `RXFC_CFG_WMASK);
    pstrb <= 4'h2;
    apb(1'b1, `RXFC_CFG_ADDR, 32'h0000_0000, r, e);
    pstrb <= 4'hF;
    apb(1'b0, `RXFC_CFG_ADDR, 0, r, e);
    chk("byte lanes", r, 32'h00FF_00FF);
    apb(1'b0, 12'h0F0, 0, r, e);
    chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
    full_duplex <= 1'b1;
    fifo_used <= 14'h0080;
    apb(1'b1, `RXFC_CFG_ADDR, 32'h0002_010E, r, e);
    repeat (20) @(posedge pclk);
    chk("pause off", pause_req, 0);
    exp_q.push_back(1'b0);
    tx_enabled <= 1'b0;
    apb(1'b1, `RXFC_CFG_ADDR, 32'h0002_0101, r, e);
    repeat (20) @(posedge pclk);
    chk("pause tx off", pause_req, 0);
    tx_enabled <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("pause on", pause_req, 1);
    apb(1'b0, `RXFC_STAT_ADDR, 0, r, e);
    chk("pause pending", r, 32'h0000_0001);
    ack_wait <= 8'($urandom % 20);
    repeat (40) @(posedge pclk);
    fifo_used <= 14'h0040;
    repeat (20) @(posedge pclk);
    exp_q.push_back(1'b1);
    fifo_used <= 14'h0020;
    repeat (40) @(posedge pclk);
    chk("pauses left", exp_q.size(), 0);
    full_duplex <= 1'b0;
    fifo_used <= 14'h0080;
    for (int i = 0; i < 32; i++) begin
      nib = 4'($urandom);
      m = 3'($urandom);
      if (i < 16) nib[0] = 1'b1;
      speed_100 <= 1'($urandom);
      apb(1'b1, `RXFC_CFG_ADDR, {16'h0002, 8'h00, i[3:0], nib}, r, e);
      on = nib[0] | (nib[1] & m[2]) | (nib[2] & m[0]) | (nib[3] & m[1]);
      x = on ? bp_cycles(i % 16, speed_100) : 0;
      @(posedge pclk);
      rx_sof <= 1'b1;
      {rx_own_match, rx_group_match, rx_all_match} <= m;
      @(posedge pclk);
      rx_sof <= 1'b0;
      n = 0;
      @(posedge pclk);
      while (backpressure === 1'b1 && n < 7000) begin
        n++;
        @(posedge pclk);
      end
      chk("jam", n + 1 >= x && n <= x + 1 && (on || n == 0), 1);
    end
    finish_test;
  end
endmodule
`default_nettype wire
